// ==== rfa_consts.vh ====
// constants for the register field access library
`ifndef RFA_CONSTS_VH
`define RFA_CONSTS_VH
`define RFA_W          8
`define RFA_T_RO       3'h0
`define RFA_T_RDSET    3'h1
`define RFA_T_RC       3'h2
`define RFA_T_WO       3'h3
`define RFA_T_WC       3'h4
`define RFA_T_WANY     3'h5
`define RFA_T_SCLR     3'h6
`define RFA_T_SS       3'h7
`define RFA_RST_VAL    8'h00
`endif

// ==== rfa_field.v ====
// one configurable register field with selectable access semantics
`timescale 1ns/1ps
`include "rfa_consts.vh"
module rfa_field #(
  parameter [2:0]        FIELD_TYPE  = `RFA_T_RO,
  parameter [`RFA_W-1:0] RESET_VALUE = `RFA_RST_VAL,
  parameter              LITE_EXEMPT = 0,
  parameter              SOFT_EXEMPT = 0
) (
  // clock and resets
  input  wire              sys_clk_i,
  input  wire              rstn_i,
  input  wire              lite_rst_i,
  input  wire              soft_rst_i,
  // software access port
  input  wire              rd_i,
  input  wire              wr_i,
  input  wire [`RFA_W-1:0] wdata_i,
  output wire [`RFA_W-1:0] rdata_o,
  // hardware side
  input  wire              hw_set_i,
  input  wire [`RFA_W-1:0] hw_value_i,
  input  wire [`RFA_W-1:0] hw_cond_i,
  input  wire [`RFA_W-1:0] hw_low_cond_i,
  output wire [`RFA_W-1:0] field_value_o,
  output wire [`RFA_W-1:0] latch_low_status_o,
  output wire [`RFA_W-1:0] latch_high_status_o,
  output wire [`RFA_W-1:0] phy_sticky_high_status_o
);

  // field register and its next value
  reg  [`RFA_W-1:0] field_reg;
  reg  [`RFA_W-1:0] field_next;
  // read strobe seen on the previous edge
  reg               rd_d_reg;
  // status vectors gathered from the per-bit slices
  wire [`RFA_W-1:0] lat_low_bits;
  wire [`RFA_W-1:0] lat_high_bits;
  wire [`RFA_W-1:0] sticky_bits;
  // access and reset qualifiers
  wire              rd_pulse;
  wire              lite_clear;
  wire              soft_clear;
  wire              part_clear;
  wire              part_hold;
  wire [`RFA_W-1:0] hw_or_bits;

  // one side effect per software read, on its first cycle
  assign rd_pulse = rd_i & ~rd_d_reg;

  // a reset kind clears only fields that are not exempt from it
  assign lite_clear = lite_rst_i & (LITE_EXEMPT == 0);
  assign soft_clear = soft_rst_i & (SOFT_EXEMPT == 0);
  assign part_clear = lite_clear | soft_clear;

  // an exempt field freezes while its reset kind is asserted and no non-exempt kind is
  assign part_hold = (lite_rst_i | soft_rst_i) & ~part_clear;

  // hardware value merged into the hardware-settable types
  assign hw_or_bits = hw_set_i ? hw_value_i : {`RFA_W{1'b0}};

  // main field next state by access type
  always @* begin
    field_next = field_reg;
    case (FIELD_TYPE)
      `RFA_T_RO: begin
        // mirrors the hardware value, writes never reach it
        field_next = hw_value_i;
      end
      `RFA_T_RDSET: begin
        // hardware set empties it, a read fills it
        if (hw_set_i) begin
          field_next = {`RFA_W{1'b0}};
        end
        if (rd_pulse) begin
          field_next = {`RFA_W{1'b1}};
        end
      end
      `RFA_T_RC: begin
        // read clears, writes ignored
        if (rd_pulse) begin
          field_next = {`RFA_W{1'b0}};
        end
        field_next = field_next | hw_or_bits;
      end
      `RFA_T_WO: begin
        // last write kept, never read back
        if (wr_i) begin
          field_next = wdata_i;
        end
      end
      `RFA_T_WC: begin
        // ones in the data clear, hardware may set again
        if (wr_i) begin
          field_next = field_reg & ~wdata_i;
        end
        field_next = field_next | hw_or_bits;
      end
      `RFA_T_WANY: begin
        // any write empties it
        if (wr_i) begin
          field_next = {`RFA_W{1'b0}};
        end
        field_next = field_next | hw_or_bits;
      end
      `RFA_T_SCLR: begin
        // set bits last one cycle, zero writes do nothing
        field_next = wr_i ? wdata_i : {`RFA_W{1'b0}};
      end
      `RFA_T_SS: begin
        // cleared bits last one cycle, one writes do nothing
        field_next = wr_i ? wdata_i : {`RFA_W{1'b1}};
      end
      default: begin
        field_next = field_reg;
      end
    endcase
  end

  // read strobe history for the single-effect rule
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rd_d_reg <= 1'b0;
    end else begin
      rd_d_reg <= rd_i;
    end
  end

  // field register: hard reset, non-exempt reset kinds, freeze, update
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      field_reg <= RESET_VALUE;
    end else if (part_clear) begin
      field_reg <= RESET_VALUE;
    end else if (part_hold) begin
      field_reg <= field_reg;
    end else begin
      field_reg <= field_next;
    end
  end

  // per-bit synchronisers and latching status
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < `RFA_W; bit_idx = bit_idx + 1) begin : g_bit
      // synchroniser stages
      reg cond_s1_reg;
      reg cond_reg;
      reg low_s1_reg;
      reg low_reg;
      // status state and next values
      reg lat_low_reg;
      reg lat_high_reg;
      reg sticky_reg;
      reg unread_reg;
      reg lat_low_next;
      reg lat_high_next;
      reg sticky_next;
      reg unread_next;

      // condition pins come from other domains: two flops each
      // only the second stage is read by logic
      always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
          cond_s1_reg <= 1'b0;
          cond_reg    <= 1'b0;
          low_s1_reg  <= 1'b0;
          low_reg     <= 1'b0;
        end else begin
          cond_s1_reg <= hw_cond_i[bit_idx];
          cond_reg    <= cond_s1_reg;
          low_s1_reg  <= hw_low_cond_i[bit_idx];
          low_reg     <= low_s1_reg;
        end
      end

      // next status; a capture beats a clearing read in the same cycle
      always @* begin
        // latched indications drop only on a read
        lat_low_next  = (rd_pulse ? 1'b0 : lat_low_reg) | low_reg;
        lat_high_next = (rd_pulse ? 1'b0 : lat_high_reg) | cond_reg;
        // sticky bit held while unread, then follows the condition
        sticky_next   = cond_reg |
                        (sticky_reg & unread_reg & ~rd_pulse);
        // a rise in the cycle of a read is still unread
        unread_next   = (unread_reg & ~rd_pulse) |
                        (cond_reg & ~sticky_reg);
      end

      // status registers with the same reset handling as the field
      always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
          lat_low_reg  <= 1'b0;
          lat_high_reg <= 1'b0;
          sticky_reg   <= 1'b0;
          unread_reg   <= 1'b0;
        end else if (part_clear) begin
          lat_low_reg  <= 1'b0;
          lat_high_reg <= 1'b0;
          sticky_reg   <= 1'b0;
          unread_reg   <= 1'b0;
        end else if (!part_hold) begin
          lat_low_reg  <= lat_low_next;
          lat_high_reg <= lat_high_next;
          sticky_reg   <= sticky_next;
          unread_reg   <= unread_next;
        end
      end

      // gather the slice into the status vectors
      assign lat_low_bits[bit_idx]  = lat_low_reg;
      assign lat_high_bits[bit_idx] = lat_high_reg;
      assign sticky_bits[bit_idx]   = sticky_reg;
    end
  endgenerate

  // readback; write-only reads zero since its value is unspecified
  assign rdata_o = (FIELD_TYPE == `RFA_T_WO) ? {`RFA_W{1'b0}} : field_reg;

  // field and status outputs straight from flip-flops
  assign field_value_o            = field_reg;
  assign latch_low_status_o       = lat_low_bits;
  assign latch_high_status_o      = lat_high_bits;
  assign phy_sticky_high_status_o = sticky_bits;

endmodule // rfa_field

// ==== rfa_field_checker.sv ====
// assertions on one register field
`timescale 1ns/1ps
module rfa_field_checker #(parameter [2:0] FIELD_TYPE = 3'h0, parameter LITE_EXEMPT = 0) (
  input wire       sys_clk_i, rstn_i, lite_rst_i, soft_rst_i, rd_i, wr_i, hw_set_i,
  input wire [7:0] wdata_i, hw_value_i, rdata_o, field_value_o
);
  wire q = !lite_rst_i && !soft_rst_i && !hw_set_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_RO: assert property (FIELD_TYPE == 3'h0 && q
    |=> field_value_o == $past(hw_value_i)) else $error("ro value");
  AST_RD: assert property (FIELD_TYPE != 3'h3 |-> rdata_o == field_value_o)
    else $error("read data");
  AST_RDSET: assert property (FIELD_TYPE == 3'h1 && $rose(rd_i) && q
    |=> field_value_o == 8'hFF) else $error("read-set field not set");
  AST_RC: assert property (FIELD_TYPE == 3'h2 && $rose(rd_i) && q
    |=> field_value_o == 8'h00) else $error("rc clear");
  AST_RCW: assert property (FIELD_TYPE == 3'h2 && wr_i && !$rose(rd_i) && q
    |=> $stable(field_value_o)) else $error("rc write");
  AST_WC: assert property (FIELD_TYPE == 3'h4 && wr_i && q
    |=> field_value_o == ($past(field_value_o) & ~$past(wdata_i))) else $error("wc");
  AST_WANY: assert property (FIELD_TYPE == 3'h5 && wr_i && q
    |=> field_value_o == 8'h00) else $error("write-any field not cleared");
  AST_SCLR: assert property (FIELD_TYPE == 3'h6 && $past(wr_i) && !wr_i && q
    |=> field_value_o == 8'h00) else $error("self-clearing field not cleared");
  AST_SS: assert property (FIELD_TYPE == 3'h7 && $past(wr_i) && !wr_i && q
    |=> field_value_o == 8'hFF) else $error("ss");
  AST_LITE: assert property (LITE_EXEMPT && lite_rst_i |=> $stable(field_value_o))
    else $error("lite");
endmodule // rfa_field_checker
bind rfa_field rfa_field_checker #(.FIELD_TYPE(FIELD_TYPE), .LITE_EXEMPT(LITE_EXEMPT))
  rfa_field_checker_i (.*);

// ==== rfa_host.sv ====
// host software model driving the field access port
`timescale 1ns/1ps
module rfa_host (
  input  wire       clk_i,
  output reg        rd_o = 1'b0,
  output reg        wr_o = 1'b0,
  output reg  [7:0] wdata_o = 8'h00 // zeros when idle
);
  // one-cycle read pulse so every read counts
  task rd;
    begin @(negedge clk_i) rd_o = 1'b1; @(negedge clk_i) rd_o = 1'b0; end
  endtask
  task wr(input [7:0] d);
    begin @(negedge clk_i); wr_o = 1'b1; wdata_o = d; @(negedge clk_i); wr_o = 1'b0; wdata_o = 8'h00; end
  endtask
  // read data is never taken, so reserved bits are not relied on
endmodule // rfa_host

// ==== test_rfa_field.sv ====
// testbench for all eight field types side by side
`timescale 1ns/1ps
module test_rfa_field;
  reg        sys_clk_i = 1'b0;
  reg        rstn_i = 1'b0;
  reg        lite_rst_i = 1'b0;
  reg        soft_rst_i = 1'b0;
  reg  [7:0] cond = 8'h00;
  reg  [7:0] lowc = 8'h00;
  reg        hset = 1'b0;
  reg  [7:0] hval = 8'h3C;
  wire       rd, wr;
  wire [7:0] wd;
  wire [7:0] fv [0:7];
  wire [7:0] rdat [0:7];
  wire [7:0] lat_hi [0:7];
  wire [7:0] lat_lo [0:7];
  wire [7:0] sh [0:7];
  integer    err_count = 0;
  integer    tests_run = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  rfa_host rfa_host_i (.clk_i(sys_clk_i), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
  genvar k;
  // one field of every type, exemptions from the index bits
  generate for (k = 0; k < 8; k = k + 1) begin : g
    rfa_field #(.FIELD_TYPE(k), .RESET_VALUE(8'h5A), .LITE_EXEMPT(k % 2),
      .SOFT_EXEMPT(k / 2 % 2)) rfa_field_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .lite_rst_i(lite_rst_i), .soft_rst_i(soft_rst_i), .rd_i(rd), .wr_i(wr),
      .wdata_i(wd), .rdata_o(rdat[k]), .hw_set_i(hset), .hw_value_i(hval),
      .hw_cond_i(cond), .hw_low_cond_i(lowc), .field_value_o(fv[k]),
      .latch_low_status_o(lat_lo[k]), .latch_high_status_o(lat_hi[k]),
      .phy_sticky_high_status_o(sh[k]));
  end endgenerate
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n); repeat (n) @(negedge sys_clk_i); endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task t_read;
    begin
      chk(rdat[2], 8'h5A);
      rfa_host_i.rd; cyc(1);
      chk(fv[2], 8'h00);
      chk(fv[1], 8'hFF);
      chk(fv[0], 8'h3C);
      $display("read test done");
    end
  endtask
  task t_write;
    begin
      rfa_host_i.wr(8'h0F);
      chk(fv[4], 8'h50);
      chk(fv[5], 8'h00);
      chk(fv[0], 8'h3C);
      chk(fv[2], 8'h00);
      chk(fv[3], 8'h0F);
      chk(fv[6], 8'h0F);
      cyc(2);
      chk(fv[6], 8'h00);
      chk(fv[7], 8'hFF);
      $display("write test done");
    end
  endtask
  task t_resets;
    begin
      soft_rst_i = 1'b1; cyc(1); soft_rst_i = 1'b0; cyc(1);
      chk(fv[4], 8'h5A);
      chk(fv[2], 8'h00);
      rfa_host_i.wr(8'h0F);
      lite_rst_i = 1'b1; cyc(1); lite_rst_i = 1'b0; cyc(1);
      chk(fv[4], 8'h5A);
      chk(fv[5], 8'h00);
      $display("reset test done");
    end
  endtask
  task t_sticky;
    begin
      cond = 8'h01; lowc = 8'h01; cyc(5); cond = 8'h00; lowc = 8'h00; cyc(5);
      chk(sh[0], 8'h01);
      chk(lat_hi[0], 8'h01);
      chk(lat_lo[0], 8'h01);
      rfa_host_i.rd; cyc(1);
      chk(sh[0], 8'h00);
      chk(lat_hi[0], 8'h00);
      chk(lat_lo[0], 8'h00);
      cond = 8'h01; cyc(5); rfa_host_i.rd; cyc(2);
      chk(sh[0], 8'h01);
      cond = 8'h00; cyc(4);
      chk(sh[0], 8'h00);
      $display("sticky test done");
    end
  endtask
  task t_hw;
    begin
      hval = 8'hA5; hset = 1'b1; cyc(1); hset = 1'b0;
      chk(fv[0], 8'hA5);
      chk(fv[1], 8'h00);
      chk(fv[2], 8'hA5);
      chk(fv[4], 8'hFF);
      chk(fv[5], 8'hA5);
      $display("hardware set test done");
    end
  endtask
  initial begin
    #200000; err_count = err_count + 1; complete_run;
  end
  initial begin
    cyc(12); rstn_i = 1'b1; cyc(1);
    t_read; t_write; t_resets; t_sticky; t_hw;
    complete_run;
  end
endmodule // test_rfa_field
